// ==== rtl/haptic_control_config_regs.sv ====
/*
  Control and configuration registers of a closed-loop haptic driver with
  trigger pin decode, resonance period averaging and standby forcing.
  Assumes the I2C slave and the playback engine run on clk; the trigger
  pin arrives asynchronously and is synchronised here.
*/
`timescale 1ns/1ps
module haptic_control_config_regs #(
  parameter logic [6:0] OWN_ADDR = 7'h2A  // arbitrary slave address
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire haptic_cfg_pkg::reg_req_type reg_req,
  output logic [7:0]                       reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic [6:0]                  bus_addr,
  input  wire logic                        bus_addr_valid,
  output logic                             bus_addr_match,
  input  wire logic [9:0]                  period_in,
  input  wire logic                        period_in_valid,
  output logic [9:0]                       resonance_period,
  output logic [2:0]                       supply_comp_percent,
  input  wire logic                        trigger_pin_in,
  output logic                             trigger_pin_out,
  output logic                             trigger_pin_oe,
  input  wire logic                        launch_write,
  input  wire logic                        launch_value,
  input  wire logic                        process_busy,
  input  wire logic                        process_irq,
  output logic                             process_start,
  output logic                             process_cancel,
  output logic                             force_standby,
  output logic [1:0]                       op_mode,
  output logic                             actuator_type,
  output logic                             open_loop
);

  // a colliding own address would make the group call gate meaningless
  if (OWN_ADDR == haptic_cfg_pkg::GROUP_CALL_ADDR) begin
    $error("own address must differ from the group call address");
  end

  haptic_cfg_pkg::state_type s_q;
  haptic_cfg_pkg::state_type s_d;

  logic [1:0]  pin_func;
  logic [1:0]  new_func;
  logic [1:0]  new_mode;
  logic        wr_one;
  logic        wr_two;
  logic        pin_rise;
  logic        pin_fall;
  logic [11:0] sum;

  assign pin_func = s_q.ctrl1[haptic_cfg_pkg::PIN_FUNC_LSB +: 2];
  assign wr_one   = reg_req.wr &&
                    reg_req.addr == haptic_cfg_pkg::CONTROL_ONE_OFFSET;
  assign wr_two   = reg_req.wr &&
                    reg_req.addr == haptic_cfg_pkg::CONTROL_TWO_OFFSET;
  assign new_func = reg_req.wdata[haptic_cfg_pkg::PIN_FUNC_LSB +: 2];
  assign new_mode = reg_req.wdata[haptic_cfg_pkg::MODE_LSB +: 2];
  assign pin_rise = s_q.pin_s2 && !s_q.pin_prev;
  assign pin_fall = !s_q.pin_s2 && s_q.pin_prev;

  always_comb begin
    s_d         = s_q;
    s_d.start   = 1'b0;
    s_d.cancel  = 1'b0;
    s_d.standby = 1'b0;
    s_d.rvalid  = 1'b0;
    sum         = 12'h000;
    // only pin_s2 looks at the first stage
    s_d.pin_s1   = trigger_pin_in;
    s_d.pin_s2   = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;

    if (wr_one) begin
      s_d.ctrl1 = reg_req.wdata;
    end
    if (wr_two) begin
      s_d.ctrl2 = reg_req.wdata;
    end
    if (reg_req.rd) begin
      s_d.rvalid = 1'b1;
      unique case (reg_req.addr)
        haptic_cfg_pkg::CONTROL_ONE_OFFSET: s_d.rdata = s_q.ctrl1;
        haptic_cfg_pkg::CONTROL_TWO_OFFSET: s_d.rdata = s_q.ctrl2;
        default:                            s_d.rdata = 8'h00;
      endcase
    end

    if (wr_one && process_busy &&
        (new_func != pin_func || new_mode != op_mode)) begin
      s_d.standby = 1'b1;
    end else begin
      unique case (pin_func)
        haptic_cfg_pkg::PIN_PULSE_TRIG: begin
          if (pin_rise) begin
            s_d.start  = !process_busy;
            s_d.cancel = process_busy;
          end else if (launch_write) begin
            s_d.start  = launch_value && !process_busy;
            s_d.cancel = !launch_value && process_busy;
          end
        end
        haptic_cfg_pkg::PIN_LEVEL_ENABLE: begin
          s_d.start  = pin_rise && !process_busy;
          s_d.cancel = pin_fall && process_busy;
        end
        haptic_cfg_pkg::PIN_IRQ_OUT: begin
          if (launch_write) begin
            s_d.start  = launch_value && !process_busy;
            s_d.cancel = !launch_value && process_busy;
          end
        end
        default: begin
          s_d.start  = 1'b0;
          s_d.cancel = 1'b0;
        end
      endcase
    end

    if (period_in_valid) begin
      s_d.hist = {s_q.hist[2:0], period_in};
    end
    for (int i = 0; i < haptic_cfg_pkg::AVG_DEPTH; i++) begin
      sum = sum + {2'h0, s_d.hist[i]};
    end
    if (s_q.ctrl1[haptic_cfg_pkg::AVG_DISABLE_BIT]) begin
      s_d.period = s_d.hist[0];
    end else begin
      s_d.period = sum[11:2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.ctrl1    <= haptic_cfg_pkg::CONTROL_ONE_RESET;
      s_q.ctrl2    <= haptic_cfg_pkg::CONTROL_TWO_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_addr_match = bus_addr_valid &&
    (bus_addr == OWN_ADDR ||
     (bus_addr == haptic_cfg_pkg::GROUP_CALL_ADDR &&
      s_q.ctrl1[haptic_cfg_pkg::GROUP_CALL_BIT]));

  always_comb begin
    unique case (s_q.ctrl1[haptic_cfg_pkg::COMP_SEL_LSB +: 2])
      2'h0:    supply_comp_percent = haptic_cfg_pkg::COMP_PCT_0;
      2'h1:    supply_comp_percent = haptic_cfg_pkg::COMP_PCT_1;
      2'h2:    supply_comp_percent = haptic_cfg_pkg::COMP_PCT_2;
      default: supply_comp_percent = haptic_cfg_pkg::COMP_PCT_3;
    endcase
  end

  assign trigger_pin_out  = 1'b0;
  assign trigger_pin_oe   = pin_func == haptic_cfg_pkg::PIN_IRQ_OUT &&
                            process_irq;

  assign op_mode          = s_q.ctrl1[haptic_cfg_pkg::MODE_LSB +: 2];
  assign actuator_type    = s_q.ctrl2[haptic_cfg_pkg::ACTUATOR_BIT];
  // loop select, 1 is open loop
  assign open_loop        = s_q.ctrl2[haptic_cfg_pkg::LOOP_BIT];

  assign reg_rdata        = s_q.rdata;
  assign reg_rvalid       = s_q.rvalid;
  assign resonance_period = s_q.period;
  assign process_start    = s_q.start;
  assign process_cancel   = s_q.cancel;
  assign force_standby    = s_q.standby;

  group_call_gate_a: assert property (
    @(posedge clk) disable iff (!resetn)
    bus_addr_valid && bus_addr == haptic_cfg_pkg::GROUP_CALL_ADDR &&
    !s_q.ctrl1[haptic_cfg_pkg::GROUP_CALL_BIT] |-> !bus_addr_match)
    else $error("group call address matched while disabled");

  period_latest_a: assert property (
    @(posedge clk) disable iff (!resetn)
    s_q.ctrl1[haptic_cfg_pkg::AVG_DISABLE_BIT] && period_in_valid &&
    !wr_one |=> resonance_period == $past(period_in))
    else $error("latest period not reported");

  comp_code_a: assert property (
    @(posedge clk) disable iff (!resetn)
    s_q.ctrl1[5:4] == 2'h3 |-> supply_comp_percent == 3'h5)
    else $error("compensation code 3 not five percent");

  pulse_trig_a: assert property (
    @(posedge clk) disable iff (!resetn)
    pin_func == haptic_cfg_pkg::PIN_PULSE_TRIG && pin_rise &&
    !process_busy && !wr_one |=> process_start)
    else $error("pulse trigger did not start");

  level_no_launch_a: assert property (
    @(posedge clk) disable iff (!resetn)
    pin_func == haptic_cfg_pkg::PIN_LEVEL_ENABLE && !pin_rise &&
    !pin_fall |=> !process_start && !process_cancel)
    else $error("launch bit acted in level mode");

  irq_pin_a: assert property (
    @(posedge clk) disable iff (!resetn)
    trigger_pin_oe |-> pin_func == haptic_cfg_pkg::PIN_IRQ_OUT &&
    process_irq && !trigger_pin_out)
    else $error("pin driven outside interrupt mode");

  func_abort_a: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_one && process_busy && new_func != pin_func
    |=> force_standby && !process_start)
    else $error("pin function change did not abort");

  mode_abort_a: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_one && process_busy && new_mode != op_mode
    |=> force_standby && op_mode == $past(new_mode))
    else $error("mode change did not abort");

  read_back_a: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_two ##1 !reg_req.wr ##1
    reg_req.rd && reg_req.addr == haptic_cfg_pkg::CONTROL_TWO_OFFSET &&
    !wr_two |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 3))
    else $error("read back mismatch");

  loop_bit_a: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_two |=> open_loop == $past(reg_req.wdata[6]) &&
    actuator_type == $past(reg_req.wdata[7]))
    else $error("loop or actuator bit not taken");

endmodule

// ==== rtl/haptic_cfg_pkg.sv ====
/*
  Constants, field positions and carrier types for the haptic control and
  configuration register pair. Assumes an I2C slave front end on the same
  clock that turns bus transactions into byte register accesses.
*/
package haptic_cfg_pkg;

  localparam logic [7:0] CONTROL_ONE_OFFSET = 8'h07;
  localparam logic [7:0] CONTROL_TWO_OFFSET = 8'h08;

  localparam logic [7:0] CONTROL_ONE_RESET  = 8'h44;
  localparam logic [7:0] CONTROL_TWO_RESET  = 8'h88;

  // control_one field positions
  localparam int GROUP_CALL_BIT   = 7;
  localparam int AVG_DISABLE_BIT  = 6;
  localparam int COMP_SEL_LSB     = 4;
  localparam int PIN_FUNC_LSB     = 2;
  localparam int MODE_LSB         = 0;
  // control_two field positions
  localparam int ACTUATOR_BIT     = 7;
  localparam int LOOP_BIT         = 6;

  localparam logic [6:0] GROUP_CALL_ADDR  = 7'h58;
  localparam int         AVG_DEPTH        = 4;

  localparam logic [1:0] PIN_PULSE_TRIG   = 2'h0;
  localparam logic [1:0] PIN_LEVEL_ENABLE = 2'h1;
  localparam logic [1:0] PIN_IRQ_OUT      = 2'h2;

  localparam logic [1:0] MODE_REALTIME    = 2'h0;
  localparam logic [1:0] MODE_SEQUENCER   = 2'h1;
  localparam logic [1:0] MODE_DIAG        = 2'h2;
  localparam logic [1:0] MODE_AUTOCAL     = 2'h3;

  // compensation in percent per select code
  localparam logic [2:0] COMP_PCT_0       = 3'h0;
  localparam logic [2:0] COMP_PCT_1       = 3'h2;
  localparam logic [2:0] COMP_PCT_2       = 3'h4;
  localparam logic [2:0] COMP_PCT_3       = 3'h5;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] rdata;
    logic       rvalid;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_prev;
    logic [3:0][9:0] hist;
    logic [9:0] period;
    logic       start;
    logic       cancel;
    logic       standby;
  } state_type;

endpackage

// ==== testbench/engine_model.sv ====
/*
  Behavioural playback engine that answers the register block.
  Assumes start, cancel and standby arrive as one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module engine_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic process_start,
  input  wire logic process_cancel,
  input  wire logic force_standby,
  output logic      process_busy
);
  // runs until cancelled or sent to standby
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      process_busy <= 1'b0;
    else if (process_cancel || force_standby)
      process_busy <= 1'b0;
    else if (process_start)
      process_busy <= 1'b1;
  end
endmodule

// ==== testbench/haptic_control_config_regs_tb.sv ====
/*
  Self-checking bench for the haptic control register pair.
  Assumes the byte register port and the engine model on one clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module haptic_control_config_regs_tb;
  logic clk, resetn, rvalid, bav, match, pv, tpin, oe, lw, lv, irq;
  logic busy, st, cn, sb, act, ol, tpo;
  logic [7:0] rdata;
  logic [6:0] baddr;
  logic [9:0] per, rper;
  logic [2:0] pct;
  logic [1:0] mode;
  haptic_cfg_pkg::reg_req_type req;
  int failures, n_checks, ns, nc, nb;

  haptic_control_config_regs #(.OWN_ADDR(7'h2A)) haptic_control_config_regs_i (
    .clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .bus_addr(baddr), .bus_addr_valid(bav),
    .bus_addr_match(match), .period_in(per), .period_in_valid(pv),
    .resonance_period(rper), .supply_comp_percent(pct),
    .trigger_pin_in(tpin), .trigger_pin_out(tpo), .trigger_pin_oe(oe),
    .launch_write(lw), .launch_value(lv), .process_busy(busy),
    .process_irq(irq), .process_start(st), .process_cancel(cn),
    .force_standby(sb), .op_mode(mode), .actuator_type(act),
    .open_loop(ol));
  engine_model engine_model_i (.clk(clk), .resetn(resetn),
    .process_start(st), .process_cancel(cn), .force_standby(sb),
    .process_busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one idle edge first, so a strobe is never lowered and raised at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    req.addr = a; req.wdata = d; req.wr = 1'b1;
    @(posedge clk); #1 req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); #1;
    req.addr = a; req.rd = 1'b1;
    @(posedge clk); #1 req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  // counts pulses seen over n cycles, current cycle first
  task automatic watch(input int n);
    ns = 0; nc = 0; nb = 0;
    repeat (n) begin
      ns += int'(st === 1'b1); nc += int'(cn === 1'b1);
      nb += int'(sb === 1'b1);
      @(posedge clk); #1;
    end
  endtask

  task automatic go(input logic v);
    lv = v; lw = 1'b1;
    @(posedge clk); #1 lw = 1'b0;
    watch(4);
  endtask

  task automatic pin(input logic v);
    tpin = v;
    watch(7);
  endtask

  task automatic t_reset;
    rd(8'h07, 8'h44);
    rd(8'h08, 8'h88);
    `CHK(mode, 2'h0)
    `CHK(act, 1'b1)
    `CHK(ol, 1'b0)
  endtask

  task automatic t_regs;
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h40);
    `CHK(act, 1'b0)
    `CHK(ol, 1'b1)
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h00);
    rd(8'h07, 8'h44);
    wr(8'h08, 8'h80);
  endtask

  task automatic t_fields;
    logic [2:0] tbl [4];
    tbl = '{3'h0, 3'h2, 3'h4, 3'h5};
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, {2'b01, 2'(i), 2'b01, 2'(i)});
      `CHK(pct, tbl[i])
      `CHK(mode, 2'(i))
    end
    wr(8'h07, 8'h44);
  endtask

  task automatic t_group;
    bav = 1'b1; baddr = 7'h58; #1;
    `CHK(match, 1'b0)
    wr(8'h07, 8'hC4);
    `CHK(match, 1'b1)
    baddr = 7'h2A; #1;
    `CHK(match, 1'b1)
    wr(8'h07, 8'h44); baddr = 7'h58; #1;
    `CHK(match, 1'b0)
    bav = 1'b0;
  endtask

  task automatic sample(input logic [9:0] p, input logic [9:0] e);
    @(posedge clk); #1;
    per = p; pv = 1'b1;
    @(posedge clk); #1 pv = 1'b0;
    `CHK(rper, e)
  endtask

  task automatic t_avg;
    wr(8'h07, 8'h04);
    sample(10'h028, 10'h00A);
    sample(10'h050, 10'h01E);
    wr(8'h07, 8'h44);
    sample(10'h008, 10'h008);
  endtask

  task automatic t_launch;
    wr(8'h07, 8'h08);
    go(1'b1);
    `CHK(ns, 1)
    irq = 1'b1; #1;
    `CHK(oe, 1'b1)
    `CHK(tpo, 1'b0)
    irq = 1'b0;
    pin(1'b1);
    `CHK(nc, 0)
    pin(1'b0);
    go(1'b0);
    `CHK(nc, 1)
  endtask

  task automatic t_standby;
    go(1'b1);
    wr(8'h07, 8'h09); watch(3);
    `CHK(nb, 1)
    `CHK(busy, 1'b0)
    go(1'b1);
    wr(8'h07, 8'h05); watch(3);
    `CHK(nb, 1)
  endtask

  task automatic t_pins;
    go(1'b1);
    `CHK(ns, 0)
    irq = 1'b1; #1;
    `CHK(oe, 1'b0)
    irq = 1'b0;
    pin(1'b1);
    `CHK(ns, 1)
    pin(1'b0);
    `CHK(nc, 1)
    wr(8'h07, 8'h01);
    pin(1'b1);
    `CHK(ns, 1)
    go(1'b0);
    `CHK(nc, 1)
    pin(1'b0);
    go(1'b1);
    `CHK(ns, 1)
  endtask

  // hang guard, far beyond the roughly 150 cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0; req = '0; baddr = 7'h00; bav = 1'b0; per = 10'h000;
    pv = 1'b0; tpin = 1'b0; lw = 1'b0; lv = 1'b0; irq = 1'b0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    t_reset(); t_regs(); t_fields(); t_group(); t_avg();
    t_launch(); t_standby(); t_pins();
    wrap_up();
  end
endmodule
